// ### hdl/uds_defs.vh
// Purpose: constants for the uart data and status register block
// Assumes: word indexes on a 32-bit avalon bus, word per register
// Notes: definitions only
`ifndef UDS_DEFS_VH
`define UDS_DEFS_VH

// offsets are register indexes; byte address is four times the index
`define UDS_IDX_DATA 12'hf40
`define UDS_IDX_STATUS 12'hf41
`define UDS_IDX_STATUS1 12'hf44
`define UDS_IDX_IRQ_STATUS 12'hf48
`define UDS_IDX_IRQ_MASK 12'hf49
`define UDS_IDX_BAUD 12'hf4a
`define UDS_ADDR_W 14

// status bit positions
`define UDS_ST_RX_AVAIL 7
`define UDS_ST_PARITY 6
`define UDS_ST_OE 5
`define UDS_ST_FRAMING 4
`define UDS_ST_BRK 3
`define UDS_ST_THE 2
`define UDS_ST_IDLE 1
`define UDS_ST_CTS 0

// interrupt status bit positions
`define UDS_IRQ_RX 0
`define UDS_IRQ_ERR 1
`define UDS_IRQ_TXE 2
`define UDS_IRQ_IDLE 3
`define UDS_IRQ_W 4

// reset values
`define UDS_RST_MASK 4'h0
`define UDS_RST_BAUD 16'h0036

// frame timing
`define UDS_OVS 16
`define UDS_DATA_BITS 8
`endif

// ### hdl/uds_top.v
// Purpose: uart data, status and interrupt registers with 8n1 transmit, 8e1 receive
// Assumes: avalon-mm slave, 32-bit data, one word per register
// Notes: parity is even and checked; parity bit sits between data/stop
`timescale 1ns/1ps
`include "uds_defs.vh"

////////////////////////////////////////////////////////////////////////
module uds_top
#(
    parameter BAUD_RESET = `UDS_RST_BAUD // divisor per oversample tick
)
(
    input wire ref_clk_i, // system clock, 100 MHz
    input wire rst_i, // async reset, high
    input wire [`UDS_ADDR_W-1:0] avs_address_i, // byte address
    input wire avs_read_i, // read strobe
    input wire avs_write_i, // write strobe
    input wire [31:0] avs_writedata_i, // write data
    input wire [3:0] avs_byteenable_i, // byte lanes
    output reg [31:0] avs_readdata_o, // read data
    output wire avs_waitrequest_o, // stall
    input wire serial_in_pin_i, // serial line in
    output wire serial_out_pin_o, // serial line out
    input wire cts_n_i, // clear to send, active low
    output wire irq_o // level interrupt
);

////////////////////////////////////////////////////////////////////////
// bus decode
wire [11:0] idx = avs_address_i[`UDS_ADDR_W-1:2]; // word index
reg ack; // answer phase flag
assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
wire acc = (avs_read_i || avs_write_i) && ack; // taken edge
wire wr = acc && avs_write_i;
wire rd = acc && avs_read_i;
wire wr_data = wr && (idx == `UDS_IDX_DATA) && avs_byteenable_i[0];
wire rd_data = rd && (idx == `UDS_IDX_DATA);
wire rd_irq = rd && (idx == `UDS_IDX_IRQ_STATUS);

// one wait state: gives registered read data
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
        ack <= 1'b0;
    else
        ack <= (avs_read_i || avs_write_i) && !ack;
end

////////////////////////////////////////////////////////////////////////
// baud tick
reg [15:0] baud_div; // software divisor
reg [15:0] baud_cnt; // down counter
wire tick = (baud_cnt == 16'h0000);

// divisor 0 would stall everything, so treat as 1
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
        baud_cnt <= 16'h0000;
    else if (tick)
        baud_cnt <= (baud_div == 16'h0000) ? 16'h0000 : baud_div - 16'h1;
    else
        baud_cnt <= baud_cnt - 16'h1;
end

////////////////////////////////////////////////////////////////////////
// transmit side
reg [7:0] tx_holding; // holding register
reg tx_holding_empty; // holding free
wire tx_busy; // shifter active
wire tx_first; // first data bit gone
wire tx_load = !tx_holding_empty && !tx_busy;
reg tx_loaded; // holding handed over, await first bit

uds_tx u_tx
(
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .start_i(tx_load),
    .data_i(tx_holding),
    .serial_out_pin_o(serial_out_pin_o),
    .busy_o(tx_busy),
    .first_bit_o(tx_first)
);
wire tx_idle = !tx_busy && tx_holding_empty;

// holding register; a write wins over the empty set at the first data bit
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        tx_holding <= 8'h00;
        tx_holding_empty <= 1'b1;
        tx_loaded <= 1'b0;
    end
    else
    begin
        if (tx_load)
            tx_loaded <= 1'b1;
        else if (tx_first)
            tx_loaded <= 1'b0;
        if (wr_data)
        begin
            tx_holding <= avs_writedata_i[7:0];
            tx_holding_empty <= 1'b0;
        end
        else if (tx_first && tx_loaded)
            tx_holding_empty <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// receive side: 8 data, even parity, 1 stop, 16x sampling
reg [1:0] rx_sync; // input synchroniser
reg [3:0] rx_sub; // tick counter in a bit
reg [3:0] rx_bit; // bit position, 0 = idle
reg [8:0] rx_shift; // data plus parity
reg rx_done; // character complete pulse
reg rx_stop; // sampled stop level
wire rx_line = rx_sync[1];

// receive framing engine
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        rx_sync <= 2'b11;
        rx_sub <= 4'h0;
        rx_bit <= 4'h0;
        rx_shift <= 9'h000;
        rx_done <= 1'b0;
        rx_stop <= 1'b1;
    end
    else
    begin
        rx_sync <= {rx_sync[0], serial_in_pin_i};
        rx_done <= 1'b0;
        if (rx_bit == 4'h0)
        begin
            rx_sub <= 4'h0;
            if (tick && !rx_line)
                rx_bit <= 4'h1; // start edge seen
        end
        else if (tick)
        begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == 4'h7 && rx_bit == 4'h1 && rx_line)
                rx_bit <= 4'h0; // false start, glitch
            else if (rx_sub == 4'hf)
            begin
                if (rx_bit == 4'hb)
                    rx_bit <= 4'h0;
                else
                    rx_bit <= rx_bit + 4'h1;
            end
            else if (rx_sub == 4'h7 && rx_bit >= 4'h2)
            begin
                if (rx_bit == 4'hb)
                begin
                    rx_stop <= rx_line;
                    rx_done <= 1'b1;
                end
                else
                    rx_shift <= {rx_line, rx_shift[8:1]};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// receive data and status flags
reg [7:0] rx_data; // receive data register
reg rx_data_available; // byte waiting
reg parity_error_flag; // parity error
reg overrun_error_flag; // overrun
reg framing_error_flag; // no stop bit
reg break_detect_flag; // all zero frame
reg new_frame_flag; // first byte of frame
reg last_multiproc_bit; // last ninth bit
wire par_bad = ^rx_shift; // even parity over data and parity
wire brk = (rx_shift == 9'h000) && !rx_stop;

// receive event sets win over read clears; status reads touch nothing
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        rx_data <= 8'h00;
        rx_data_available <= 1'b0;
        parity_error_flag <= 1'b0;
        overrun_error_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        break_detect_flag <= 1'b0;
        new_frame_flag <= 1'b0;
        last_multiproc_bit <= 1'b0;
    end
    else
    begin
        if (rd_data)
        begin
            rx_data_available <= 1'b0;
            parity_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            break_detect_flag <= 1'b0;
            new_frame_flag <= 1'b0;
            last_multiproc_bit <= 1'b0;
            if (!rx_data_available)
                overrun_error_flag <= 1'b0;
        end
        if (rx_done)
        begin
            if (rx_data_available && !rd_data)
            begin
                overrun_error_flag <= 1'b1;
                if (brk)
                    break_detect_flag <= 1'b1;
            end
            else
            begin
                rx_data <= rx_shift[7:0];
                rx_data_available <= 1'b1;
                parity_error_flag <= par_bad;
                framing_error_flag <= !rx_stop;
                break_detect_flag <= brk;
            end
        end
    end
end

// live status word, bit 0 follows the pin
wire [7:0] status = {rx_data_available, parity_error_flag,
    overrun_error_flag, framing_error_flag, break_detect_flag,
    tx_holding_empty, tx_idle, cts_n_i};

////////////////////////////////////////////////////////////////////////
// interrupts: sticky, cleared by reading the interrupt status register
reg [`UDS_IRQ_W-1:0] irq_status; // sticky events
reg [`UDS_IRQ_W-1:0] irq_mask; // enables
reg tx_idle_q; // for idle edge
wire [`UDS_IRQ_W-1:0] irq_ev = {tx_idle && !tx_idle_q,
    wr_data ? 1'b0 : (tx_first && tx_loaded),
    rx_done && (rx_data_available || par_bad || !rx_stop || brk),
    rx_done};
assign irq_o = |(irq_status & irq_mask);

// read clear, new events win
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        irq_status <= {`UDS_IRQ_W{1'b0}};
        irq_mask <= `UDS_RST_MASK;
        tx_idle_q <= 1'b1;
        baud_div <= BAUD_RESET;
    end
    else
    begin
        tx_idle_q <= tx_idle;
        irq_status <= (rd_irq ? {`UDS_IRQ_W{1'b0}} : irq_status) | irq_ev;
        if (wr && idx == `UDS_IDX_IRQ_MASK && avs_byteenable_i[0])
            irq_mask <= avs_writedata_i[`UDS_IRQ_W-1:0];
        if (wr && idx == `UDS_IDX_BAUD)
        begin
            if (avs_byteenable_i[0])
                baud_div[7:0] <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1])
                baud_div[15:8] <= avs_writedata_i[15:8];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// read data register; unmapped reads zero
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
        avs_readdata_o <= 32'h0000_0000;
    else if ((avs_read_i && !ack))
    begin
        case (idx)
            `UDS_IDX_DATA: avs_readdata_o <= {24'h0, rx_data};
            `UDS_IDX_STATUS: avs_readdata_o <= {24'h0, status};
            `UDS_IDX_STATUS1: avs_readdata_o <=
                {30'h0, new_frame_flag, last_multiproc_bit};
            `UDS_IDX_IRQ_STATUS: avs_readdata_o <= {28'h0, irq_status};
            `UDS_IDX_IRQ_MASK: avs_readdata_o <= {28'h0, irq_mask};
            `UDS_IDX_BAUD: avs_readdata_o <= {16'h0, baud_div};
            default: avs_readdata_o <= 32'h0000_0000;
        endcase
    end
end
endmodule

// ### hdl/uds_tx.v
// Purpose: transmit shifter for one 8n1 character
// Assumes: tick_i pulses once per oversample tick (16 per bit)
// Notes: first_bit_o pulses when data bit 0 has fully gone out
`timescale 1ns/1ps
`include "uds_defs.vh"
module uds_tx
(
    input wire ref_clk_i, // system clock
    input wire rst_i, // async reset, high
    input wire tick_i, // oversample tick
    input wire start_i, // load pulse
    input wire [7:0] data_i, // byte to send
    output reg serial_out_pin_o, // serial line out
    output wire busy_o, // character in flight
    output wire first_bit_o // first data bit shifted out
);

////////////////////////////////////////////////////////////////////////
reg [9:0] shift; // stop, data, start
reg [3:0] bit_cnt; // bits left
reg [3:0] sub_cnt; // ticks inside a bit

assign busy_o = (bit_cnt != 4'h0);
// end of data bit 0, not of the start bit: eight bit times to refill
assign first_bit_o = tick_i && busy_o && (sub_cnt == 4'hf) &&
    (bit_cnt == 4'h9);

// shift process; idle line high
always @(posedge ref_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        shift <= 10'h3ff;
        bit_cnt <= 4'h0;
        sub_cnt <= 4'h0;
        serial_out_pin_o <= 1'b1;
    end
    else if (start_i && !busy_o)
    begin
        shift <= {1'b1, data_i, 1'b0};
        bit_cnt <= 4'ha;
        sub_cnt <= 4'h0;
    end
    else if (busy_o && tick_i)
    begin
        serial_out_pin_o <= shift[0];
        sub_cnt <= sub_cnt + 4'h1;
        if (sub_cnt == 4'hf)
        begin
            shift <= {1'b1, shift[9:1]};
            bit_cnt <= bit_cnt - 4'h1;
        end
    end
    else if (!busy_o)
    begin
        serial_out_pin_o <= 1'b1; // idle
    end
end
endmodule

// ### tb/tb_uart_data_status_regs.sv
// Purpose: self-checking bench for the uart data and status block
// Assumes: BAUD_RESET 0, so 16 clocks per bit on both lines
// Notes: byte lanes tied on; peer drives rx and captures tx
`timescale 1ns/1ps
`include "uds_defs.vh"
module tb_uart_data_status_regs;
    localparam [13:0] A_D = {`UDS_IDX_DATA, 2'b00}; // data
    localparam [13:0] A_S = {`UDS_IDX_STATUS, 2'b00}; // status
    localparam [13:0] A_IS = {`UDS_IDX_IRQ_STATUS, 2'b00}; // irq
    localparam [13:0] A_IM = {`UDS_IDX_IRQ_MASK, 2'b00}; // mask
    localparam [23:0] ED = 24'h330f00; // parity, framing, break
    localparam [23:0] ES = 24'hc6969e; // their status
    logic clk = 0, rst = 1, rd = 0, wr = 0, cts_n = 1;
    logic [13:0] adr = 14'h0;
    logic [31:0] wd = 32'h0, q, rdat;
    wire wreq, txl, rxl, irq;
    int err_total = 0, num_checks = 0, cyc = 0;
    uds_top #(.BAUD_RESET(16'h0000)) dut
    (
        .ref_clk_i(clk), // clock
        .rst_i(rst), // reset
        .avs_address_i(adr), // address
        .avs_read_i(rd), // read
        .avs_write_i(wr), // write
        .avs_writedata_i(wd), // write data
        .avs_byteenable_i(4'hf), // all lanes
        .avs_readdata_o(rdat), // read data
        .avs_waitrequest_o(wreq), // stall
        .serial_in_pin_i(rxl), // from peer
        .serial_out_pin_o(txl), // to peer
        .cts_n_i(cts_n), // clear to send
        .irq_o(irq) // interrupt
    );
    uds_peer peer (.clk_i(clk), .line_i(txl), .line_o(rxl));
    initial
    forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // one transfer, held until waitrequest samples low
    task automatic bus(input logic w, input logic [13:0] a,
        input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [13:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // status with the live cts level in bit 0
    function automatic logic [31:0] st(input logic [7:0] f);
        return {24'h0, f[7:1], cts_n};
    endfunction
    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(A_S, st(8'h06));
        rdc(14'h0, 32'h0);
        bus(1'b1, A_D, 32'ha5);
        rdc(A_S, st(8'h00));
        // start bit gone, data bit 0 still on the line: still full
        repeat (20) @(posedge clk);
        rdc(A_S, st(8'h00));
        repeat (17) @(posedge clk);
        rdc(A_S, st(8'h04));
        bus(1'b1, A_D, 32'h3c);
        repeat (400) @(posedge clk);
        chk(peer.got[0], 32'ha5);
        chk(peer.got[1], 32'h3c);
        rdc(A_S, st(8'h06));
        rdc(A_IS, 32'hc);
        cts_n <= 1'b0;
        @(posedge clk);
        rdc(A_S, st(8'h06));
        // unmasked receive raises the interrupt
        bus(1'b1, A_IM, 32'h1);
        peer.send(8'h5a, 1'b0, 1'b1);
        chk(irq, 32'h1);
        rdc(A_S, st(8'h86));
        rdc(A_S, st(8'h86));
        rdc(A_IS, 32'h1);
        @(negedge clk);
        chk(irq, 32'h0);
        rdc(A_D, 32'h5a);
        rdc(A_S, st(8'h06));
        rdc({`UDS_IDX_STATUS1, 2'b00}, 32'h0);
        // masked error frames: parity, framing, break
        bus(1'b1, A_IM, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            peer.send(ED[23-8*k -: 8], k == 0, k == 0);
            chk(irq, 32'h0);
            rdc(A_S, st(ES[23-8*k -: 8]));
            rdc(A_D, {24'h0, ED[23-8*k -: 8]});
            rdc(A_S, st(8'h06));
        end
        rdc(A_IS, 32'h3);
        // second byte arrives unread
        peer.send(8'h11, 1'b0, 1'b1);
        peer.send(8'h22, 1'b0, 1'b1);
        rdc(A_S, st(8'ha6));
        rdc(A_D, 32'h11);
        rdc(A_S, st(8'h26));
        rdc(A_D, 32'h11);
        rdc(A_S, st(8'h06));
        report_and_stop();
    end
endmodule

// ### tb/uds_chk.sv
// Purpose: bus and status relations of the uart data/status block
// Assumes: one clock, async reset high, one wait state per access
// Notes: sees only the top ports; bound below
`timescale 1ns/1ps
`include "uds_defs.vh"
module uds_chk
(
    input wire ref_clk_i, // clock
    input wire rst_i, // reset
    input wire [`UDS_ADDR_W-1:0] avs_address_i, // address
    input wire avs_read_i, // read
    input wire avs_write_i, // write
    input wire [31:0] avs_writedata_i, // unused
    input wire [3:0] avs_byteenable_i, // unused
    input wire [31:0] avs_readdata_o, // read data
    input wire avs_waitrequest_o, // stall
    input wire serial_in_pin_i, // unused
    input wire serial_out_pin_o, // tx line
    input wire cts_n_i, // clear to send
    input wire irq_o // interrupt
);
    localparam [13:0] A_ST = {`UDS_IDX_STATUS, 2'b00}; // status
    // a read taken, and a status read taken
    wire rd_done = avs_read_i && !avs_waitrequest_o;
    wire st_rd = rd_done && avs_address_i == A_ST;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////
    property p_wf; $rose(avs_read_i) || $rose(avs_write_i)
        |-> avs_waitrequest_o; endproperty
    a_wf: assert property (p_wf) else $error("no wait");
    property p_wo; (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o; endproperty
    a_wo: assert property (p_wo) else $error("long wait");
    // read data must not drift between reads
    property p_rh; !avs_read_i |=> $stable(avs_readdata_o); endproperty
    a_rh: assert property (p_rh) else $error("data drift");
    property p_ct; st_rd && $stable(cts_n_i)
        |-> avs_readdata_o[0] == cts_n_i; endproperty
    a_ct: assert property (p_ct) else $error("cts bit");
    property p_hi; st_rd |-> avs_readdata_o[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("status width");
    property p_il; st_rd && avs_readdata_o[1] |-> serial_out_pin_o;
    endproperty
    a_il: assert property (p_il) else $error("idle but busy");
    // holding full means the transmitter cannot report idle
    property p_ti; st_rd && !avs_readdata_o[2] |-> !avs_readdata_o[1];
    endproperty
    a_ti: assert property (p_ti) else $error("idle, full");
    property p_un; rd_done && avs_address_i == 14'h0
        |-> avs_readdata_o == 32'h0; endproperty
    a_un: assert property (p_un) else $error("unmapped");
    c_rda: cover property (st_rd && avs_readdata_o[7]);
    c_ovr: cover property (st_rd && avs_readdata_o[5]);
    c_irq: cover property (irq_o);
endmodule
bind uds_top uds_chk u_chk (.ref_clk_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .serial_in_pin_i,
    .serial_out_pin_o, .cts_n_i, .irq_o);

// ### tb/uds_peer.sv
// Purpose: remote serial peer for the uart block
// Assumes: 16 clocks per bit, even parity on frames it sends, odd parity when bad is set
// Notes: device frames carry no parity; bytes land in got
`timescale 1ns/1ps
module uds_peer
(
    input wire logic clk_i, // clock
    input wire logic line_i, // device tx
    output logic line_o // device rx
);
    logic [7:0] got [0:3]; // bytes captured
    int n = 0; // capture count
    initial line_o = 1'b1; // idle high
    // one frame: start, data lsb first, parity, stop
    task automatic send(input logic [7:0] d, input logic bad, stp);
        logic [10:0] f;
        f = {stp, ^d ^ bad, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            line_o <= f[i];
            repeat (16) @(posedge clk_i);
        end
        line_o <= 1'b1; // back to idle so the next start is seen
        repeat (32) @(posedge clk_i);
    endtask
    // capture device frames at mid-bit
    initial
    forever
    begin
        @(negedge line_i);
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (16) @(posedge clk_i);
            got[n][i] = line_i;
        end
        n++;
    end
endmodule
